// ===== rtl/mhf_framer.sv
// MAC header framer: builds transmit headers and parses received segment control
`timescale 1ns/10ps
module mhf_framer #(
	parameter int HDR_BYTES = mhf_pkg::HDR_MAX
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic tx_start,
	input wire logic [15:0] tx_fc,
	input wire logic [23:0] tx_seg_ctrl,
	input wire logic [7:0] tx_seq,
	input wire logic [15:0] tx_dst_pan,
	input wire logic [63:0] tx_dst_addr,
	input wire logic [15:0] tx_src_pan,
	input wire logic [63:0] tx_src_addr,
	input wire logic [39:0] tx_aux_sec,
	input wire logic ack_send,
	input wire logic rx_valid,
	input wire logic rx_first,
	input wire logic [7:0] rx_data,
	output logic tx_busy,
	output logic tx_reject,
	output logic hdr_valid,
	output logic hdr_last,
	output logic [7:0] hdr_data,
	output logic [2:0] phy_delim_type,
	output logic phy_ack_send_request,
	output logic [23:0] rx_seg_ctrl,
	output logic rx_seg_valid
);
	mhf_pkg::mhf_state_t state_reg;
	logic [7:0] buf_reg [HDR_BYTES];
	logic [5:0] len_reg;
	logic [5:0] idx_reg;
	logic hdr_valid_reg, hdr_last_reg, busy_reg, reject_reg, ack_reg, seg_valid_reg;
	logic [7:0] hdr_data_reg;
	logic [2:0] delim_reg;
	logic [23:0] seg_reg;
	logic [15:0] fc_next;
	logic [7:0] asm_next [HDR_BYTES];
	logic [5:0] len_next;
	logic aux_bad;

	mhf_parse_if pif ();

	// Address field byte count from mode
	function automatic logic [5:0] addr_len(input logic [1:0] mode);
		case (mode)
			mhf_pkg::AMODE_SHORT: addr_len = 6'h2;
			mhf_pkg::AMODE_EXT: addr_len = 6'h8;
			default: addr_len = 6'h0;
		endcase
	endfunction

	// ===========================================
	// Frame control cleanup
	always_comb begin
		fc_next = tx_fc;
		fc_next[mhf_pkg::FC_PEND_BIT] = 1'b0;
		fc_next[mhf_pkg::FC_VER_LSB +: 2] = 2'h0;
		if (tx_fc[mhf_pkg::FC_TYPE_LSB +: 3] == mhf_pkg::FTYPE_ACK)
			fc_next[mhf_pkg::FC_TYPE_LSB +: 3] = mhf_pkg::FTYPE_DATA;
	end

	// Reject frames asking for an ack frame type
	assign aux_bad = tx_fc[mhf_pkg::FC_TYPE_LSB +: 3] == mhf_pkg::FTYPE_ACK;

	// ===========================================
	// Header assembly in field order
	always_comb begin
		logic [5:0] p;
		logic [5:0] n;
		p = 6'h0;
		n = 6'h0;
		for (int i = 0; i < HDR_BYTES; i++) asm_next[i] = 8'h0;
		asm_next[0] = fc_next[7:0];
		asm_next[1] = fc_next[15:8];
		for (int i = 0; i < 3; i++) asm_next[2 + i] = tx_seg_ctrl[i*8 +: 8];
		asm_next[5] = tx_seq;
		p = 6'h6;
		n = addr_len(fc_next[mhf_pkg::FC_DMODE_LSB +: 2]);
		if (n != 6'h0) begin
			asm_next[p] = tx_dst_pan[7:0];
			asm_next[p + 6'h1] = tx_dst_pan[15:8];
			p = p + 6'h2;
		end
		for (int i = 0; i < 8; i++) if (6'(i) < n) asm_next[p + 6'(i)] = tx_dst_addr[i*8 +: 8];
		p = p + n;
		n = addr_len(fc_next[mhf_pkg::FC_SMODE_LSB +: 2]);
		if (n != 6'h0 && !fc_next[mhf_pkg::FC_PANCOMP_BIT]) begin
			asm_next[p] = tx_src_pan[7:0];
			asm_next[p + 6'h1] = tx_src_pan[15:8];
			p = p + 6'h2;
		end
		for (int i = 0; i < 8; i++) if (6'(i) < n) asm_next[p + 6'(i)] = tx_src_addr[i*8 +: 8];
		p = p + n;
		// Security header is absent or exactly five bytes
		if (fc_next[mhf_pkg::FC_SEC_BIT]) begin
			for (int i = 0; i < 5; i++) asm_next[p + 6'(i)] = tx_aux_sec[i*8 +: 8];
			p = p + 6'(mhf_pkg::AUX_LEN_PRESENT);
		end else begin
			p = p + 6'(mhf_pkg::AUX_LEN_ABSENT);
		end
		len_next = p;
	end

	// ===========================================
	// Transmit state machine
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_reg <= mhf_pkg::MHF_IDLE;
			idx_reg <= 6'h0;
			len_reg <= 6'h0;
			busy_reg <= 1'b0;
			reject_reg <= 1'b0;
		end else begin
			reject_reg <= 1'b0;
			case (state_reg)
				mhf_pkg::MHF_IDLE: begin
					if (tx_start && aux_bad) begin
						reject_reg <= 1'b1;
					end else if (tx_start) begin
						len_reg <= len_next;
						idx_reg <= 6'h0;
						busy_reg <= 1'b1;
						state_reg <= mhf_pkg::MHF_EMIT;
					end
				end
				mhf_pkg::MHF_EMIT: begin
					idx_reg <= idx_reg + 6'h1;
					if (idx_reg == len_reg - 6'h1)
						state_reg <= mhf_pkg::MHF_DONE;
				end
				mhf_pkg::MHF_DONE: begin
					busy_reg <= 1'b0;
					state_reg <= mhf_pkg::MHF_IDLE;
				end
				default: state_reg <= mhf_pkg::MHF_IDLE;
			endcase
		end
	end

	// Header buffer capture
	always_ff @(posedge sys_clk) begin
		if (state_reg == mhf_pkg::MHF_IDLE && tx_start && !aux_bad)
			for (int i = 0; i < HDR_BYTES; i++) buf_reg[i] <= asm_next[i];
	end

	// ===========================================
	// Byte output and PHY delimiter
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hdr_valid_reg <= 1'b0;
			hdr_last_reg <= 1'b0;
			hdr_data_reg <= 8'h0;
			delim_reg <= mhf_pkg::DT_NO_ACK;
		end else begin
			hdr_valid_reg <= state_reg == mhf_pkg::MHF_EMIT;
			hdr_last_reg <= state_reg == mhf_pkg::MHF_EMIT && idx_reg == len_reg - 6'h1;
			hdr_data_reg <= state_reg == mhf_pkg::MHF_EMIT ? buf_reg[idx_reg] : 8'h0;
			if (state_reg == mhf_pkg::MHF_IDLE && tx_start && !aux_bad)
				delim_reg <= tx_fc[mhf_pkg::FC_ACKREQ_BIT] ? mhf_pkg::DT_ACK_REQ : mhf_pkg::DT_NO_ACK;
		end
	end

	// Acknowledgement through the PHY request only
	always_ff @(posedge sys_clk) begin
		if (reset)
			ack_reg <= 1'b0;
		else
			ack_reg <= ack_send;
	end

	// ===========================================
	// Receive segment control parsing
	assign pif.rx_valid = rx_valid;
	assign pif.rx_first = rx_first;
	assign pif.rx_data = rx_data;

	mhf_seg_parser u_parser (
		.sys_clk(sys_clk),
		.reset(reset),
		.pif(pif)
	);

	// Registered receive outputs
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			seg_reg <= 24'h0;
			seg_valid_reg <= 1'b0;
		end else begin
			seg_valid_reg <= pif.seg_valid;
			if (pif.seg_valid) seg_reg <= pif.seg_ctrl;
		end
	end

	assign tx_busy = busy_reg;
	assign tx_reject = reject_reg;
	assign hdr_valid = hdr_valid_reg;
	assign hdr_last = hdr_last_reg;
	assign hdr_data = hdr_data_reg;
	assign phy_delim_type = delim_reg;
	assign phy_ack_send_request = ack_reg;
	assign rx_seg_ctrl = seg_reg;
	assign rx_seg_valid = seg_valid_reg;

	// ===========================================
	// Checks
	sequence s_start;
		state_reg == mhf_pkg::MHF_IDLE && tx_start && !aux_bad;
	endsequence

	AST_NO_ACK_TYPE: assert property (@(posedge sys_clk) disable iff (reset)
		hdr_valid && idx_reg == 6'h1 |-> hdr_data[2:0] != mhf_pkg::FTYPE_ACK)
		else $error("ack frame type emitted");
	AST_ACK_PHY: assert property (@(posedge sys_clk) disable iff (reset)
		ack_send |=> phy_ack_send_request)
		else $error("phy ack request missing");
	AST_PEND_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
		s_start |=> ##1 (hdr_valid && !hdr_data[mhf_pkg::FC_PEND_BIT]))
		else $error("frame pending bit set");
	AST_DELIM: assert property (@(posedge sys_clk) disable iff (reset)
		s_start |=> phy_delim_type == ($past(tx_fc[mhf_pkg::FC_ACKREQ_BIT]) ? mhf_pkg::DT_ACK_REQ : mhf_pkg::DT_NO_ACK))
		else $error("delimiter type mismatch");
	AST_VER_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
		s_start |=> ##2 (hdr_valid && hdr_data[5:4] == 2'h0))
		else $error("frame version not zero");
	AST_AUX_LEN: assert property (@(posedge sys_clk) disable iff (reset)
		s_start and (tx_fc[mhf_pkg::FC_SEC_BIT] && tx_fc[13:10] == 4'h0 && tx_fc[15:14] == 2'h0)
		|=> len_reg == 6'h6 + 6'(mhf_pkg::AUX_LEN_PRESENT))
		else $error("aux header length not five");
	AST_ORDER_SEQ: assert property (@(posedge sys_clk) disable iff (reset)
		s_start |=> ##6 (hdr_valid && hdr_data == $past(tx_seq, 7)))
		else $error("sequence number out of order");
	AST_SEG_TX: assert property (@(posedge sys_clk) disable iff (reset)
		s_start |=> ##3 (hdr_valid && hdr_data == $past(tx_seg_ctrl[7:0], 4)))
		else $error("segment control not inserted");
endmodule // mhf_framer

// ===== rtl/mhf_pkg.sv
// Package of constants and types for the MAC header field framer
package mhf_pkg;
	// Frame control field layout (16 bits, transmitted low byte first)
	localparam int FC_TYPE_LSB = 0;
	localparam int FC_SEC_BIT = 3;
	localparam int FC_PEND_BIT = 4;
	localparam int FC_ACKREQ_BIT = 5;
	localparam int FC_PANCOMP_BIT = 6;
	localparam int FC_DMODE_LSB = 10;
	localparam int FC_VER_LSB = 12;
	localparam int FC_SMODE_LSB = 14;
	// Frame type codes
	localparam logic [2:0] FTYPE_ACK = 3'h2;
	localparam logic [2:0] FTYPE_DATA = 3'h1;
	// Addressing modes
	localparam logic [1:0] AMODE_NONE = 2'h0;
	localparam logic [1:0] AMODE_SHORT = 2'h2;
	localparam logic [1:0] AMODE_EXT = 2'h3;
	// Auxiliary security header lengths
	localparam logic [3:0] AUX_LEN_ABSENT = 4'h0;
	localparam logic [3:0] AUX_LEN_PRESENT = 4'h5;
	// Segment control field length in bytes
	localparam logic [3:0] SEG_LEN = 4'h3;
	// PHY delimiter types
	localparam logic [2:0] DT_ACK_REQ = 3'h0;
	localparam logic [2:0] DT_NO_ACK = 3'h1;
	// Header byte count limit
	localparam int HDR_MAX = 40;
	// Framer states
	typedef enum logic [1:0] {
		MHF_IDLE = 2'b00,
		MHF_EMIT = 2'b01,
		MHF_DONE = 2'b10
	} mhf_state_t;
endpackage

// ===== rtl/mhf_parse_if.sv
// Interface between the framer and its segment control parser
`timescale 1ns/10ps
interface mhf_parse_if;
	logic rx_valid;
	logic rx_first;
	logic [7:0] rx_data;
	logic [23:0] seg_ctrl;
	logic seg_valid;
	modport framer (output rx_valid, output rx_first, output rx_data, input seg_ctrl, input seg_valid);
	modport parser (input rx_valid, input rx_first, input rx_data, output seg_ctrl, output seg_valid);
endinterface

// ===== rtl/mhf_seg_parser.sv
// Receive side parser of the segment control fields
`timescale 1ns/10ps
module mhf_seg_parser (
	input wire logic sys_clk,
	input wire logic reset,
	mhf_parse_if.parser pif
);
	logic [1:0] count_reg;
	logic [23:0] seg_reg;
	logic valid_reg;

	// ===========================================
	// Byte collection, first byte of the header restarts
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			count_reg <= 2'h0;
			seg_reg <= 24'h0;
			valid_reg <= 1'b0;
		end else begin
			valid_reg <= 1'b0;
			if (pif.rx_valid) begin
				if (pif.rx_first) begin
					seg_reg <= {16'h0, pif.rx_data};
					count_reg <= 2'h1;
				end else if (count_reg != 2'h0 && count_reg < 2'h3) begin
					seg_reg[count_reg*8 +: 8] <= pif.rx_data;
					count_reg <= count_reg + 2'h1;
					valid_reg <= (count_reg == 2'h2);
				end
			end
		end
	end

	assign pif.seg_ctrl = seg_reg;
	assign pif.seg_valid = valid_reg;

	AST_SEG_DONE: assert property (@(posedge sys_clk) disable iff (reset)
		pif.rx_valid && pif.rx_first ##1 (pif.rx_valid && !pif.rx_first) [*2] |=> valid_reg)
		else $error("segment control not reported after three bytes");
endmodule // mhf_seg_parser

// ===== sim/mhf_phy_sink.sv
// PHY side model that collects the header byte stream
`timescale 1ns/10ps
module mhf_phy_sink (
	input wire logic sys_clk,
	input wire logic hdr_valid,
	input wire logic hdr_last,
	input wire logic [7:0] hdr_data
);
	logic [7:0] got[$];
	int frames = 0;
	// ==========
	// Capture
	// Take every offered byte; the PHY never stalls the stream
	always @(posedge sys_clk) begin
		if (hdr_valid === 1'b1) begin
			got.push_back(hdr_data);
			if (hdr_last === 1'b1) frames++;
		end
	end
endmodule // mhf_phy_sink

// ===== sim/testbench.sv
// Self-checking testbench of the MAC header framer
`timescale 1ns/10ps
module testbench;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic tx_start = 1'b0, ack_send = 1'b0, rx_valid = 1'b0, rx_first = 1'b0;
	logic [15:0] tx_fc = 16'h0, tx_dst_pan = 16'hd1d0, tx_src_pan = 16'h5150;
	logic [23:0] tx_seg_ctrl = 24'hc2c1c0;
	logic [7:0] tx_seq = 8'h5a, rx_data = 8'h0;
	logic [63:0] tx_dst_addr = 64'ha7a6a5a4a3a2a1a0, tx_src_addr = 64'hb7b6b5b4b3b2b1b0;
	logic [39:0] tx_aux_sec = 40'he4e3e2e1e0;
	logic tx_busy, tx_reject, hdr_valid, hdr_last, phy_ack_send_request, rx_seg_valid;
	logic [7:0] hdr_data;
	logic [2:0] phy_delim_type;
	logic [23:0] rx_seg_ctrl;
	logic [7:0] exp_q[$];
	int err_total = 0;
	int checked = 0;
	always #10 sys_clk = ~sys_clk;
	mhf_framer mhf_framer_inst (.sys_clk(sys_clk), .reset(reset), .tx_start(tx_start), .tx_fc(tx_fc),
		.tx_seg_ctrl(tx_seg_ctrl), .tx_seq(tx_seq), .tx_dst_pan(tx_dst_pan), .tx_dst_addr(tx_dst_addr),
		.tx_src_pan(tx_src_pan), .tx_src_addr(tx_src_addr), .tx_aux_sec(tx_aux_sec), .ack_send(ack_send),
		.rx_valid(rx_valid), .rx_first(rx_first), .rx_data(rx_data), .tx_busy(tx_busy),
		.tx_reject(tx_reject), .hdr_valid(hdr_valid), .hdr_last(hdr_last), .hdr_data(hdr_data),
		.phy_delim_type(phy_delim_type), .phy_ack_send_request(phy_ack_send_request),
		.rx_seg_ctrl(rx_seg_ctrl), .rx_seg_valid(rx_seg_valid));
	mhf_phy_sink mhf_phy_sink_inst (.sys_clk(sys_clk), .hdr_valid(hdr_valid), .hdr_last(hdr_last),
		.hdr_data(hdr_data));
	// ==========
	// Helpers
	task test_done;
		if (err_total == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Wait on negedges for a design flag, bounded
	task wait_flag(input int which);
		int n;
		for (n = 0; n < 60; n++) begin
			@(negedge sys_clk);
			if (which == 0 && hdr_last === 1'b1) return;
			if (which == 1 && tx_reject === 1'b1) return;
			if (which == 2 && rx_seg_valid === 1'b1) return;
		end
		err_total++;
		test_done;
	endtask
	task put_addr(input logic [1:0] m, input logic [63:0] a);
		int i;
		for (i = 0; i < (m == 2'h3 ? 8 : (m == 2'h2 ? 2 : 0)); i++) exp_q.push_back(a[8*i+:8]);
	endtask
	// ==========
	// Scenarios
	// Send one header and compare the stream byte by byte
	task send_frame(input logic [15:0] fc, input logic [2:0] dt);
		logic [15:0] f;
		int i;
		f = fc & 16'hcfef;
		exp_q = {f[7:0], f[15:8], tx_seg_ctrl[7:0], tx_seg_ctrl[15:8], tx_seg_ctrl[23:16], tx_seq};
		if (f[11:10] != 2'h0) exp_q = {exp_q, tx_dst_pan[7:0], tx_dst_pan[15:8]};
		put_addr(f[11:10], tx_dst_addr);
		if (f[15:14] != 2'h0 && !f[6]) exp_q = {exp_q, tx_src_pan[7:0], tx_src_pan[15:8]};
		put_addr(f[15:14], tx_src_addr);
		for (i = 0; f[3] && i < 5; i++) exp_q.push_back(tx_aux_sec[8*i+:8]);
		mhf_phy_sink_inst.got.delete();
		@(posedge sys_clk) tx_fc <= fc;
		tx_start <= 1'b1;
		@(posedge sys_clk) tx_start <= 1'b0;
		wait_flag(0);
		chk("busy_at_last", tx_busy, 1'b1);
		chk("last_position", mhf_phy_sink_inst.got.size(), exp_q.size() - 1);
		repeat (3) @(posedge sys_clk);
		chk("busy_after", tx_busy, 1'b0);
		chk("delim_type", phy_delim_type, dt);
		chk("hdr_length", mhf_phy_sink_inst.got.size(), exp_q.size());
		foreach (exp_q[k]) chk("hdr_byte", mhf_phy_sink_inst.got[k], exp_q[k]);
	endtask
	// Acknowledgement frame type is refused and emits nothing
	task send_ack_type;
		mhf_phy_sink_inst.got.delete();
		@(posedge sys_clk) tx_fc <= 16'h0022;
		tx_start <= 1'b1;
		@(posedge sys_clk) tx_start <= 1'b0;
		wait_flag(1);
		@(negedge sys_clk) chk("reject_pulse", tx_reject, 1'b0);
		chk("busy_on_reject", tx_busy, 1'b0);
		repeat (4) @(posedge sys_clk);
		chk("ack_type_bytes", mhf_phy_sink_inst.got.size(), 0);
	endtask
	// Acknowledge through the PHY request pulse
	task ack_pulse;
		@(posedge sys_clk) ack_send <= 1'b1;
		@(posedge sys_clk) ack_send <= 1'b0;
		@(negedge sys_clk) chk("ack_req_high", phy_ack_send_request, 1'b1);
		@(negedge sys_clk) chk("ack_req_low", phy_ack_send_request, 1'b0);
	endtask
	// Parse three received segment control bytes
	task rx_seg;
		@(posedge sys_clk) rx_valid <= 1'b1;
		rx_first <= 1'b1;
		rx_data <= 8'h31;
		@(posedge sys_clk) rx_first <= 1'b0;
		rx_data <= 8'h42;
		@(posedge sys_clk) rx_data <= 8'h53;
		@(posedge sys_clk) rx_valid <= 1'b0;
		wait_flag(2);
		chk("rx_seg_ctrl", rx_seg_ctrl, 24'h534231);
	endtask
	// ==========
	// Main sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		@(negedge sys_clk) chk("delim_reset", phy_delim_type, 3'h1);
		send_frame(16'hb831, 3'h0);
		send_frame(16'hcc49, 3'h1);
		send_ack_type;
		send_frame(16'h8021, 3'h0);
		send_frame(16'h0009, 3'h1);
		ack_pulse;
		rx_seg;
		chk("frame_count", mhf_phy_sink_inst.frames, 4);
		test_done;
	end
endmodule // testbench
